// ### src/spm_regs.svh
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

// ----------------------------------------
// request decode
// ----------------------------------------
`define PORT_SEL_SECOND 16'h0002
`define CMD_PORT_SETUP 16'hfff0
`define RSV_ADDR_FIRST 16'h0651
`define RSV_ADDR_LAST 16'h0716

// ----------------------------------------
// field limits
// ----------------------------------------
`define RATE_MAX 3'h6
`define PARITY_MAX 2'h2
`define ID_W 64

// ----------------------------------------
// reset configuration
// ----------------------------------------
`define RST_RATE 3'h6
`define RST_PARITY 2'h0
`define RST_STOP 1'h0
`define RST_ID 64'h0

// ----------------------------------------
// programmer loss timing
// ----------------------------------------
`define PGM_LOSS_S 20
`define CLK_HZ 10000000
`define LOSS_W 28

`endif

// ### src/spm_pkg.sv
`include "spm_regs.svh"

package spm_pkg;

  typedef enum logic [3:0] {
    PROTO_SNP = 4'b0001,
    PROTO_RTU = 4'b0011,
    PROTO_CUSTOM = 4'b0101
  } proto_e;

  typedef struct packed {
    proto_e proto;
    logic [2:0] rate;
    logic [1:0] parity;
    logic stop;
    logic [`ID_W-1:0] devId;
  } port_cfg_s;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_PGM = 1'b1
  } attach_e;

endpackage : spm_pkg

// ### src/spm_if.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// loss timer control
// ----------------------------------------
interface loss_timer_if;
  logic run;
  logic kick;
  logic expired;
  modport ctrl(output run, output kick, input expired);
  modport timer(input run, input kick, output expired);
endinterface : loss_timer_if

// ----------------------------------------
// most recent configuration store
// ----------------------------------------
interface recent_cfg_if;
  import spm_pkg::*;
  logic wrEn;
  port_cfg_s wrData;
  port_cfg_s rdData;
  modport user(output wrEn, output wrData, input rdData);
  modport store(input wrEn, input wrData, output rdData);
endinterface : recent_cfg_if

`default_nettype wire

// ### src/pgm_loss_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "spm_regs.svh"

module pgm_loss_timer #(
  parameter int unsigned LOSS_CYCLES = `PGM_LOSS_S * `CLK_HZ
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // control
  loss_timer_if.timer tmr
);
  import spm_pkg::*;

  localparam logic [`LOSS_W-1:0] LastCount = `LOSS_W'(LOSS_CYCLES - 1);

  logic [`LOSS_W-1:0] count_q;
  logic [`LOSS_W-1:0] count_d;
  wire atLast = (count_q == LastCount);

  // silence long enough: loss, unless traffic arrives this cycle
  assign tmr.expired = clkEn & tmr.run & ~tmr.kick & atLast;
  assign count_d = (!tmr.run || tmr.kick || atLast) ? '0 : count_q + 1'b1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (clkEn) begin
      count_q <= count_d;
    end
  end

  loss_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tmr.expired |-> count_q == LastCount && tmr.run)
    else $error("loss declared before full silent interval");

  loss_count_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && tmr.run && !tmr.kick && !atLast |=> count_q == $past(count_q) + 1'b1)
    else $error("loss timer skipped a count");

endmodule : pgm_loss_timer

`default_nettype wire

// ### src/recent_cfg_reg.sv
`timescale 1ns/10ps
`default_nettype none
`include "spm_regs.svh"

module recent_cfg_reg (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // store port
  recent_cfg_if.store rc
);
  import spm_pkg::*;

  port_cfg_s cfg_q;

  assign rc.rdData = cfg_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '{PROTO_RTU, `RST_RATE, `RST_PARITY, `RST_STOP, `RST_ID};
    end else if (clkEn && rc.wrEn) begin
      cfg_q <= rc.wrData;
    end
  end

endmodule : recent_cfg_reg

`default_nettype wire

// ### src/serial_port_protocol_manager.sv
`timescale 1ns/10ps
`default_nettype none
`include "spm_regs.svh"

// Behaviour
// - requests routed only when port selector is 2
// - programmer seen under RTU installs programmer protocol
// - programmer recognised only with matching serial settings
// - no autobaud while RTU or programmer active
// - programmer loss installs most recent protocol
// - reinstalled protocol restarts from initial state
// - loss after 20 s silence; RTU held off
// - store while attached deferred until loss
// - attached: reject requests programmer protocol lacks
// - setup while attached only updates recent protocol
// - multidrop detection needs matching controller identifier
module serial_port_protocol_manager #(
  parameter int unsigned LOSS_CYCLES = `PGM_LOSS_S * `CLK_HZ
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // application service request
  input wire logic reqValid,
  input wire logic [15:0] reqPort,
  input wire logic [15:0] reqCmd,
  input wire logic [15:0] reqBlockAddr,
  input wire spm_pkg::port_cfg_s reqCfg,
  output logic reqAccept,
  output logic reqReject,
  output logic reqFwd,
  // configuration store
  input wire logic storeValid,
  input wire spm_pkg::port_cfg_s storeCfg,
  // line receiver
  input wire logic rxPgmFrame,
  input wire logic [2:0] rxRate,
  input wire logic [1:0] rxParity,
  input wire logic rxStop,
  input wire logic [`ID_W-1:0] rxDestId,
  input wire logic multidrop,
  // protocol control
  output spm_pkg::port_cfg_s activeCfg,
  output logic pgmAttached,
  output logic protoRestart,
  output logic rtuEnable,
  output logic autobaudEn
);
  import spm_pkg::*;

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  function automatic logic isSetup(input logic [15:0] cmd);
    return cmd == `CMD_PORT_SETUP;
  endfunction : isSetup

  function automatic logic cfgOk(input port_cfg_s cfg);
    logic protoGood;
    protoGood = (cfg.proto == PROTO_SNP) || (cfg.proto == PROTO_RTU) ||
                (cfg.proto == PROTO_CUSTOM);
    return protoGood && (cfg.rate <= `RATE_MAX) && (cfg.parity <= `PARITY_MAX);
  endfunction : cfgOk

  // ----------------------------------------
  // state
  // ----------------------------------------
  attach_e state_q;
  attach_e state_d;
  port_cfg_s activeCfg_q;
  port_cfg_s activeCfg_d;
  logic protoRestart_q;
  logic protoRestart_d;
  logic reqValid_q;

  loss_timer_if tmr();
  recent_cfg_if rc();

  pgm_loss_timer #(
    .LOSS_CYCLES(LOSS_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .tmr(tmr)
  );

  recent_cfg_reg u_recent (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .rc(rc)
  );

  // ----------------------------------------
  // programmer detection
  // ----------------------------------------
  wire inRun = (state_q == ST_RUN);
  wire inPgm = (state_q == ST_PGM);
  wire rtuActive = inRun && (activeCfg_q.proto == PROTO_RTU);
  wire cfgMatch = (rxRate == activeCfg_q.rate) && (rxParity == activeCfg_q.parity) &&
                  (rxStop == activeCfg_q.stop);
  // destination id compared in packed order, first character low byte
  wire idMatch = (rxDestId == activeCfg_q.devId);
  wire idOk = !multidrop || idMatch;
  wire attachHit = clkEn && rtuActive && rxPgmFrame && cfgMatch && idOk;
  wire pgmTraffic = clkEn && inPgm && rxPgmFrame && idOk;
  wire lossEv = inPgm && tmr.expired;

  assign tmr.run = inPgm;
  assign tmr.kick = pgmTraffic;

  // ----------------------------------------
  // service requests
  // ----------------------------------------
  wire reqEdge = clkEn && reqValid && !reqValid_q;
  wire reqHit = reqEdge && (reqPort == `PORT_SEL_SECOND);
  wire addrBad = (reqBlockAddr >= `RSV_ADDR_FIRST) &&
                 (reqBlockAddr <= `RSV_ADDR_LAST);
  wire reqSetup = isSetup(reqCmd);
  wire setupBad = reqSetup && !cfgOk(reqCfg);
  wire pgmLacks = inPgm && !reqSetup;

  assign reqReject = reqHit && (addrBad || setupBad || pgmLacks);
  assign reqAccept = reqHit && !reqReject;
  assign reqFwd = reqAccept && !reqSetup;

  // ----------------------------------------
  // most recent protocol
  // ----------------------------------------
  wire setupWr = reqAccept && reqSetup;
  wire storeWr = clkEn && storeValid && cfgOk(storeCfg);
  wire newestWr = setupWr || storeWr;
  wire port_cfg_s newestCfg = setupWr ? reqCfg : storeCfg;
  wire port_cfg_s recentCfg = newestWr ? newestCfg : rc.rdData;
  // attached: writes only update the recent protocol
  wire applyNow = inRun && newestWr && !attachHit;

  assign rc.wrEn = newestWr;
  assign rc.wrData = newestCfg;

  // ----------------------------------------
  // next state and active protocol
  // ----------------------------------------
  wire port_cfg_s pgmCfg = '{PROTO_SNP, activeCfg_q.rate, activeCfg_q.parity,
                             activeCfg_q.stop, activeCfg_q.devId};

  assign state_d = attachHit ? ST_PGM :
                   lossEv ? ST_RUN : state_q;
  assign activeCfg_d = attachHit ? pgmCfg :
                       lossEv ? recentCfg :
                       applyNow ? newestCfg : activeCfg_q;
  assign protoRestart_d = lossEv || applyNow;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RUN;
      activeCfg_q <= '{PROTO_RTU, `RST_RATE, `RST_PARITY, `RST_STOP, `RST_ID};
      protoRestart_q <= 1'b0;
      reqValid_q <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      activeCfg_q <= activeCfg_d;
      protoRestart_q <= protoRestart_d;
      reqValid_q <= reqValid;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign activeCfg = activeCfg_q;
  assign pgmAttached = inPgm;
  assign protoRestart = protoRestart_q;
  assign rtuEnable = rtuActive;
  // autobaud only for a plain programmer-protocol port, never under RTU
  assign autobaudEn = inRun && (activeCfg_q.proto == PROTO_SNP);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  port_route_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    reqEdge && (reqPort != `PORT_SEL_SECOND) |-> !reqAccept && !reqReject && !reqFwd)
    else $error("request for another port was acted on");

  attach_rtu_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    attachHit |=> inPgm && activeCfg_q.proto == PROTO_SNP &&
                  activeCfg_q.rate == $past(activeCfg_q.rate))
    else $error("programmer attach did not install programmer protocol");

  cfg_match_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && inRun && rxPgmFrame && !cfgMatch |=> inRun)
    else $error("programmer accepted with mismatched serial settings");

  no_autobaud_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (inPgm || activeCfg_q.proto == PROTO_RTU) |-> !autobaudEn)
    else $error("autobaud enabled under RTU or programmer");

  restore_recent_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    lossEv && clkEn |=> inRun && activeCfg_q == $past(recentCfg))
    else $error("loss did not install most recent protocol");

  restart_pulse_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    lossEv && clkEn |=> protoRestart ##1 (!clkEn || !protoRestart || $past(protoRestart_d)))
    else $error("reinstalled protocol not restarted");

  rtu_blocked_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    inPgm |-> !rtuEnable)
    else $error("RTU enabled while programmer attached");

  deferred_store_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && inPgm && storeWr && !lossEv |=> activeCfg_q == $past(activeCfg_q))
    else $error("store applied while programmer attached");

  reject_rtu_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    reqHit && inPgm && !reqSetup |-> reqReject && !reqFwd)
    else $error("unsupported request accepted while attached");

  setup_defer_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    setupWr && inPgm && !lossEv |=> inPgm && rc.rdData == $past(reqCfg) &&
                                    activeCfg_q.proto == PROTO_SNP)
    else $error("setup while attached not deferred");

  single_shot_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (clkEn && reqAccept) ##1 (clkEn && reqValid) |-> !reqAccept && !reqReject)
    else $error("held request executed twice");

  reserved_addr_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    reqHit && addrBad |-> reqReject && !reqAccept)
    else $error("reserved command block address accepted");

  pgm_id_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && inRun && rxPgmFrame && multidrop && !idMatch |=> inRun)
    else $error("programmer attached with wrong identifier");

  kick_timer_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    pgmTraffic |-> !lossEv ##1 (inPgm || !clkEn))
    else $error("loss declared despite programmer traffic");

  route_answer_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    reqHit |-> reqAccept != reqReject)
    else $error("served request got no single answer");

  bad_setup_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    reqHit && reqSetup && !cfgOk(reqCfg) |-> reqReject && !reqAccept)
    else $error("invalid port setup accepted");

  attach_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    attachHit |=> !protoRestart)
    else $error("programmer attach restarted the protocol");

  non_rtu_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && inRun && rxPgmFrame && activeCfg_q.proto != PROTO_RTU |=> inRun)
    else $error("programmer attached without RTU active");

  rtu_resume_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    lossEv |=> rtuEnable == ($past(recentCfg.proto) == PROTO_RTU))
    else $error("RTU engine state wrong after programmer loss");

  run_apply_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    setupWr && inRun && !attachHit |=> protoRestart && activeCfg_q == $past(reqCfg))
    else $error("run state setup not installed with restart");

  pgm_snp_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    inPgm |-> activeCfg_q.proto == PROTO_SNP)
    else $error("attached port not under programmer protocol");

  pgm_setup_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    reqHit && inPgm && reqSetup && !addrBad && cfgOk(reqCfg) |-> reqAccept && !reqFwd)
    else $error("valid setup refused while attached");

  kick_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    tmr.kick |=> !tmr.expired)
    else $error("loss declared right after programmer traffic");

endmodule : serial_port_protocol_manager

`default_nettype wire

// ### verif/pgm_terminal.sv
`timescale 1ns/10ps
`default_nettype none

module pgm_terminal (
  // clock
  input wire logic clk_sys,
  // scenario control
  input wire logic fire,
  input wire logic [2:0] cfgRate,
  input wire logic [1:0] cfgParity,
  input wire logic cfgStop,
  input wire logic [63:0] cfgId,
  // line receiver view
  output logic rxPgmFrame,
  output logic [2:0] rxRate,
  output logic [1:0] rxParity,
  output logic rxStop,
  output logic [63:0] rxDestId
);
  initial begin
    rxPgmFrame = 1'b0;
    rxRate = 3'h0;
    rxParity = 2'h0;
    rxStop = 1'b0;
    rxDestId = 64'h0;
  end

  // ----------------------------------------
  // settings lines toggle outside frames
  // ----------------------------------------
  always @(posedge clk_sys) begin
    rxPgmFrame <= fire;
    if (fire) begin
      rxRate <= cfgRate;
      rxParity <= cfgParity;
      rxStop <= cfgStop;
      rxDestId <= cfgId;
    end else begin
      rxRate <= ~rxRate;
      rxParity <= ~rxParity;
      rxStop <= ~rxStop;
      rxDestId <= ~rxDestId;
    end
  end
endmodule : pgm_terminal

`default_nettype wire

// ### verif/tb_serial_port_protocol_manager.sv
`timescale 1ns/10ps
`default_nettype none
`include "spm_regs.svh"

module tb_serial_port_protocol_manager;
  import spm_pkg::*;
  localparam int LOSS = 16;
  logic clk_sys, rst_n, clkEn, reqValid, storeValid, multidrop, fire, fStop;
  logic rxPgmFrame, rxStop, reqAccept, reqReject, reqFwd;
  logic pgmAttached, protoRestart, rtuEnable, autobaudEn;
  logic [15:0] reqPort, reqCmd, reqBlockAddr;
  logic [2:0] rxRate, fRate;
  logic [1:0] rxParity, fParity;
  logic [63:0] rxDestId, fId;
  port_cfg_s reqCfg, storeCfg, activeCfg, expCfg, nextCfg, recent;
  int err_count, tests_run, seed, n;

  serial_port_protocol_manager #(.LOSS_CYCLES(LOSS)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .clkEn(clkEn), .reqValid(reqValid), .reqPort(reqPort), .reqCmd(reqCmd),
    .reqBlockAddr(reqBlockAddr), .reqCfg(reqCfg), .reqAccept(reqAccept),
    .reqReject(reqReject), .reqFwd(reqFwd), .storeValid(storeValid), .storeCfg(storeCfg),
    .rxPgmFrame(rxPgmFrame), .rxRate(rxRate), .rxParity(rxParity), .rxStop(rxStop),
    .rxDestId(rxDestId), .multidrop(multidrop), .activeCfg(activeCfg),
    .pgmAttached(pgmAttached), .protoRestart(protoRestart), .rtuEnable(rtuEnable),
    .autobaudEn(autobaudEn));

  pgm_terminal term (.clk_sys(clk_sys), .fire(fire), .cfgRate(fRate), .cfgParity(fParity),
    .cfgStop(fStop), .cfgId(fId), .rxPgmFrame(rxPgmFrame), .rxRate(rxRate),
    .rxParity(rxParity), .rxStop(rxStop), .rxDestId(rxDestId));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // exp = {accept, reject, forward, restart one cycle later}
  task automatic request(input logic [15:0] port, input logic [15:0] cmd,
                         input logic [15:0] addr, input port_cfg_s c, input logic [3:0] exp);
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqPort <= port;
    reqCmd <= cmd;
    reqBlockAddr <= addr;
    reqCfg <= c;
    #1;
    check({reqAccept, reqReject, reqFwd}, exp[3:1]);
    @(posedge clk_sys);
    reqValid <= 1'b0;
    #1;
    check(protoRestart, exp[0]);
    @(posedge clk_sys);
  endtask : request

  task automatic frame(input logic [2:0] r, input logic [1:0] p, input logic s,
                       input logic [63:0] id);
    @(posedge clk_sys);
    fire <= 1'b1;
    fRate <= r;
    fParity <= p;
    fStop <= s;
    fId <= id;
    @(posedge clk_sys);
    fire <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : frame

  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    end_of_test();
  end

  // ----------------------------------------
  // main sequence with reference state
  // ----------------------------------------
  initial begin
    seed = 69532;
    err_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    reqValid = 1'b0;
    reqPort = 16'h0;
    reqCmd = 16'h0;
    reqBlockAddr = 16'h0;
    reqCfg = '0;
    storeValid = 1'b0;
    storeCfg = '0;
    multidrop = 1'b0;
    fire = 1'b0;
    fRate = 3'h0;
    fParity = 2'h0;
    fStop = 1'b0;
    fId = 64'h0;
    expCfg = '{PROTO_RTU, `RST_RATE, `RST_PARITY, `RST_STOP, `RST_ID};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    check(activeCfg, expCfg);
    check({pgmAttached, rtuEnable, autobaudEn}, 3'b010);
    request(16'h0003, 16'h0001, 16'h0100, expCfg, 4'b0000);
    request(16'h0002, 16'h0001, 16'h0651, expCfg, 4'b0100);
    request(16'h0002, 16'h0001, 16'h0716, expCfg, 4'b0100);
    request(16'h0002, 16'h0001, 16'h0650, expCfg, 4'b1010);
    for (n = 0; n < 3; n++) begin
      nextCfg = expCfg;
      nextCfg.rate = 3'($unsigned($random(seed)) % 7);
      nextCfg.parity = 2'($unsigned($random(seed)) % 3);
      nextCfg.stop = 1'($random(seed));
      nextCfg.devId = {$random(seed), $random(seed)};
      nextCfg.devId[15:0] = {8'h42, 8'h41};
      request(16'h0002, 16'hfff0, 16'h0100, nextCfg, 4'b1001);
      expCfg = nextCfg;
      check(activeCfg, expCfg);
    end
    // enable left high for two cycles: acted on once
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqCmd <= 16'h0001;
    #1;
    check({reqAccept, reqReject, reqFwd}, 3'b101);
    @(posedge clk_sys);
    #1;
    check({reqAccept, reqReject}, 2'b00);
    @(posedge clk_sys);
    reqValid <= 1'b0;
    @(posedge clk_sys);
    nextCfg = expCfg;
    nextCfg.rate = 3'h7;
    request(16'h0002, 16'hfff0, 16'h0100, nextCfg, 4'b0100);
    check(activeCfg, expCfg);
    frame(expCfg.rate ^ 3'h1, expCfg.parity, expCfg.stop, expCfg.devId);
    check(pgmAttached, 1'b0);
    frame(expCfg.rate, expCfg.parity, ~expCfg.stop, expCfg.devId);
    check(pgmAttached, 1'b0);
    @(posedge clk_sys);
    multidrop <= 1'b1;
    frame(expCfg.rate, expCfg.parity, expCfg.stop, expCfg.devId ^ 64'h1);
    check(pgmAttached, 1'b0);
    frame(expCfg.rate, expCfg.parity, expCfg.stop, expCfg.devId);
    check(pgmAttached, 1'b1);
    recent = expCfg;
    expCfg.proto = PROTO_SNP;
    check(activeCfg, expCfg);
    check({rtuEnable, autobaudEn}, 2'b00);
    request(16'h0002, 16'h0001, 16'h0100, expCfg, 4'b0100);
    nextCfg = recent;
    nextCfg.proto = PROTO_SNP;
    nextCfg.rate = 3'h4;
    request(16'h0002, 16'hfff0, 16'h0100, nextCfg, 4'b1000);
    check(activeCfg, expCfg);
    nextCfg.rate = 3'h3;
    @(posedge clk_sys);
    storeValid <= 1'b1;
    storeCfg <= nextCfg;
    @(posedge clk_sys);
    storeValid <= 1'b0;
    recent = nextCfg;
    #1;
    check(activeCfg, expCfg);
    frame(expCfg.rate, expCfg.parity, expCfg.stop, expCfg.devId);
    for (n = 0; n < 4; n++) begin
      repeat (10) @(posedge clk_sys);
      frame(expCfg.rate, expCfg.parity, expCfg.stop, expCfg.devId);
    end
    check(pgmAttached, 1'b1);
    check(rtuEnable, 1'b0);
    n = 0;
    while (pgmAttached === 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(n >= LOSS && n <= LOSS + 2, 1'b1);
    check(protoRestart, 1'b1);
    check(activeCfg, recent);
    check({pgmAttached, autobaudEn}, 2'b01);
    frame(recent.rate, recent.parity, recent.stop, recent.devId);
    check(pgmAttached, 1'b0);
    end_of_test();
  end
endmodule : tb_serial_port_protocol_manager

`default_nettype wire
